// ---- inc/sodcc_pkg.sv ----
// constants and types shared by the fifo output drive and clock control block
package sodcc_pkg;

    // ***********************************************
    // clock and one-shot timing
    // ***********************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int DESKEW_NS = 45;
    localparam int CLEAR_NS = 400;
    // least widths round up to whole cycles
    localparam logic [7:0] DESKEW_CYCLES = 8'((DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CLEAR_CYCLES = 8'((CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ***********************************************
    // widths and field positions
    // ***********************************************
    localparam int DATA_W = 18;
    localparam int FIFO_CHIPS = 5;
    localparam int CSR_W = 16;
    localparam int TRANSFER_ERROR_BIT = 14;
    localparam int CLEAR_BIT = 5;

    // ***********************************************
    // values after reset, and the all-ready pattern
    // ***********************************************
    localparam logic VALID_RST = 1'b0;
    localparam logic PERMIT_RST = 1'b1;
    localparam logic FLAG_RST = 1'b0;
    localparam logic [DATA_W-1:0] HOLD_RST = 18'h00000;
    localparam logic [FIFO_CHIPS-1:0] READY_RST = 5'h00;
    localparam logic [FIFO_CHIPS-1:0] READY_ALL = 5'h1F;
    localparam logic [7:0] COUNT_RST = 8'h00;

    // ***********************************************
    // pop sequencer states
    // ***********************************************
    typedef enum logic [1:0] {
        SODCC_IDLE = 2'b00,
        SODCC_POP = 2'b01,
        SODCC_LOAD = 2'b10
    } sodcc_state_e;

endpackage : sodcc_pkg

// ---- rtl/sodcc_pulse.sv ----
// retriggerable one-shot counting a fixed number of clock cycles
`timescale 1ns/1ns
module sodcc_pulse
    import sodcc_pkg::*;
#(
    parameter logic [7:0] CYCLES = 8'h01
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic start_i,
    output logic active_o,
    output logic done_o
);
    logic [7:0] count;

    // a counter replaces the analog one-shot, width never below the minimum
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count <= COUNT_RST;
        end else if (clk_en_i) begin
            if (start_i) begin
                count <= CYCLES;
            end else if (count != COUNT_RST) begin
                count <= count - 8'h01;
            end
        end
    end

    assign active_o = (count != COUNT_RST);
    assign done_o = (count == 8'h01) && !start_i;

endmodule : sodcc_pulse

// ---- rtl/sodcc_output.sv ----
// fifo output stage, holding register, drive clock gating and fifo clear
`timescale 1ns/1ns
// Operation
// - word available only when all five chips ready
// - pop needs word and permit; clear sets permit
// - each pop gives a 45 ns deskew
// - pop trailing edge starts 45 ns load pulse
// - valid set after load unless stop marker
// - valid blocks pops; running pop completes
// - buffer read clears valid at cycle end
// - write: drive clock trailing edge clears valid
// - read/verify: strobe release clears valid
// - read/verify: mismatch freezes holding register
// - write: underrun if top empty, not final
// - reading empty buffer sets underrun flag
// - drive clock passes only without inhibit, overflow
// - drive edges lead, controller acts trailing
// - transfer error sampled on sync clock, inhibits
// - error flag cleared only by fifo clear
// - inhibit on transfer or data late error
// - clear stretched to at least 400 ns
// - clear from bit, reset, init, power, go
// - write clock returned gated by write mode
module sodcc_output
    import sodcc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic [FIFO_CHIPS-1:0] fifo_out_ready_i,
    input wire logic [DATA_W-1:0] fifo_data_i,
    input wire logic stop_marker_at_top_i,
    input wire logic sync_clk_i,
    input wire logic write_mode_i,
    input wire logic read_or_verify_mode_i,
    input wire logic data_strobe_i,
    input wire logic compare_mismatch_i,
    input wire logic buffer_register_read_select_i,
    input wire logic buffer_read_cycle_strobe_i,
    input wire logic final_word_flag_i,
    input wire logic device_count_overflow_i,
    input wire logic [CSR_W-1:0] control_status_one_i,
    input wire logic control_status_two_write_i,
    input wire logic [CSR_W-1:0] control_status_two_data_i,
    input wire logic bus_init_i,
    input wire logic power_fail_indication_i,
    input wire logic command_start_clear_i,
    output logic top_word_available_o,
    output logic fifo_pop_o,
    output logic holding_load_pulse_o,
    output logic [DATA_W-1:0] output_holding_register_o,
    output logic holding_valid_flag_o,
    output logic output_underrun_flag_o,
    output logic data_late_error_o,
    output logic transfer_error_flag_o,
    output logic device_clock_inhibit_o,
    output logic drive_clk_o,
    output logic write_clk_o,
    output logic fifo_clear_pulse_o
);

    // ***********************************************
    // helpers
    // ***********************************************
    function automatic logic fell(input logic prev, input logic cur);
        fell = prev && !cur;
    endfunction : fell

    // ***********************************************
    // pin synchronisers
    // ***********************************************
    logic [FIFO_CHIPS-1:0] rdy_s1, rdy_s2;
    logic [DATA_W-1:0] data_s1, data_s2;
    logic stop_s1, stop_s2;
    logic sclk_s1, sclk_s2, sclk_s3;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdy_s1 <= READY_RST;
            rdy_s2 <= READY_RST;
            data_s1 <= HOLD_RST;
            data_s2 <= HOLD_RST;
            stop_s1 <= FLAG_RST;
            stop_s2 <= FLAG_RST;
            sclk_s1 <= FLAG_RST;
            sclk_s2 <= FLAG_RST;
            sclk_s3 <= FLAG_RST;
        end else if (clk_en_i) begin
            rdy_s1 <= fifo_out_ready_i;
            rdy_s2 <= rdy_s1;
            data_s1 <= fifo_data_i;
            data_s2 <= data_s1;
            stop_s1 <= stop_marker_at_top_i;
            stop_s2 <= stop_s1;
            sclk_s1 <= sync_clk_i;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
        end
    end

    // ***********************************************
    // decode
    // ***********************************************
    sodcc_state_e state, next_state;
    logic pop_permit, stop_latched, underrun, err_flag, drive_q, init_pending;
    logic rd_strobe_q, ds_q, clear_q, avail_q;
    logic deskew_active, deskew_done, load_active, load_done, clr_active;

    wire word_avail = (rdy_s2 == READY_ALL);
    wire sclk_rise = sclk_s2 && !sclk_s3;
    wire sclk_fall = fell(sclk_s3, sclk_s2);
    wire drive_fall = sclk_fall && drive_q;
    wire start_pop = (state == SODCC_IDLE) && avail_q && pop_permit;
    wire end_pop = (state == SODCC_POP) && !deskew_active && !avail_q;
    wire valid_set = load_done && !stop_latched;
    wire clr_read = fell(rd_strobe_q, buffer_read_cycle_strobe_i)
        && buffer_register_read_select_i;
    wire clr_write = write_mode_i && drive_fall;
    // mismatch holds the clearing clock low so the bad word stays for software
    wire clr_verify = read_or_verify_mode_i && fell(ds_q, data_strobe_i)
        && !compare_mismatch_i;
    wire valid_clear = clr_read || clr_write || clr_verify;
    wire late_write = write_mode_i && drive_fall && !avail_q && !final_word_flag_i;
    wire late_read = buffer_read_cycle_strobe_i && buffer_register_read_select_i
        && !holding_valid_flag_o;
    wire clr_req = (control_status_two_write_i && control_status_two_data_i[CLEAR_BIT])
        || bus_init_i || power_fail_indication_i || command_start_clear_i
        || init_pending;
    wire inhibit = err_flag || underrun;
    wire err_arrive = sclk_rise && control_status_one_i[TRANSFER_ERROR_BIT];

    // ***********************************************
    // one-shots
    // ***********************************************
    sodcc_pulse #(.CYCLES(DESKEW_CYCLES)) u_deskew (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .start_i(start_pop),
        .active_o(deskew_active),
        .done_o(deskew_done)
    );

    sodcc_pulse #(.CYCLES(DESKEW_CYCLES)) u_load (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .start_i(end_pop),
        .active_o(load_active),
        .done_o(load_done)
    );

    sodcc_pulse #(.CYCLES(CLEAR_CYCLES)) u_clear (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .start_i(clr_req),
        .active_o(clr_active),
        .done_o()
    );

    // ***********************************************
    // pop sequencer
    // ***********************************************
    always_comb begin
        next_state = state;
        case (state)
            SODCC_IDLE: begin
                if (start_pop) begin
                    next_state = SODCC_POP;
                end
            end
            SODCC_POP: begin
                if (end_pop) begin
                    next_state = SODCC_LOAD;
                end
            end
            SODCC_LOAD: begin
                if (load_done) begin
                    next_state = SODCC_IDLE;
                end
            end
            default: begin
                next_state = SODCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= SODCC_IDLE;
        end else if (clk_en_i) begin
            state <= clear_q ? SODCC_IDLE : next_state;
        end
    end

    // ***********************************************
    // holding register and flags
    // ***********************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            output_holding_register_o <= HOLD_RST;
            holding_valid_flag_o <= VALID_RST;
            pop_permit <= PERMIT_RST;
            stop_latched <= FLAG_RST;
        end else if (clk_en_i) begin
            if (start_pop) begin
                stop_latched <= stop_s2;
            end
            if (load_done) begin
                output_holding_register_o <= data_s2;
            end
            if (clear_q) begin
                holding_valid_flag_o <= VALID_RST;
                pop_permit <= PERMIT_RST;
            end else if (valid_set) begin
                // a load landing with a clear is not marked valid, the clear wins
                holding_valid_flag_o <= 1'b1;
                pop_permit <= 1'b0;
            end else if (valid_clear) begin
                holding_valid_flag_o <= 1'b0;
                pop_permit <= 1'b1;
            end
        end
    end

    // ***********************************************
    // errors, drive clock and clear
    // ***********************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            underrun <= FLAG_RST;
            err_flag <= FLAG_RST;
            drive_q <= FLAG_RST;
            write_clk_o <= FLAG_RST;
            clear_q <= FLAG_RST;
            init_pending <= 1'b1;
            rd_strobe_q <= FLAG_RST;
            ds_q <= FLAG_RST;
            avail_q <= FLAG_RST;
        end else if (clk_en_i) begin
            init_pending <= 1'b0;
            rd_strobe_q <= buffer_read_cycle_strobe_i;
            ds_q <= data_strobe_i;
            avail_q <= word_avail;
            clear_q <= clr_req || clr_active;
            if (late_write || late_read) begin
                underrun <= 1'b1;
            end else if (clear_q) begin
                underrun <= FLAG_RST;
            end
            // sampled on the sync clock so the gate never chops a drive clock
            if (clear_q) begin
                err_flag <= FLAG_RST;
            end else if (err_arrive) begin
                err_flag <= 1'b1;
            end
            // an error caught on this rise withholds the pulse, so no runt clock escapes
            drive_q <= sclk_s2 && !inhibit && !err_arrive && !device_count_overflow_i;
            write_clk_o <= sclk_s2 && write_mode_i;
        end
    end

    assign top_word_available_o = avail_q;
    assign fifo_pop_o = (state == SODCC_POP);
    assign holding_load_pulse_o = load_active;
    assign output_underrun_flag_o = underrun;
    assign data_late_error_o = underrun;
    assign transfer_error_flag_o = err_flag;
    assign device_clock_inhibit_o = inhibit;
    assign drive_clk_o = drive_q;
    assign fifo_clear_pulse_o = clear_q;

    // ***********************************************
    // checks
    // ***********************************************
    int unsigned pop_len, clr_len;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pop_len <= 0;
            clr_len <= 0;
        end else if (clk_en_i) begin
            pop_len <= fifo_pop_o ? pop_len + 1 : 0;
            clr_len <= clear_q ? clr_len + 1 : 0;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i || !clk_en_i);

    sequence s_pop_end;
        $fell(fifo_pop_o) && !$past(clear_q);
    endsequence
    sequence s_load_run;
        holding_load_pulse_o [*8];
    endsequence

    AST_AVAIL_ALL_FIVE: assert property (top_word_available_o |-> $past(rdy_s2) == READY_ALL)
        else $error("word available without all five ready");
    AST_POP_PERMIT: assert property ($rose(fifo_pop_o) |-> $past(avail_q) && $past(pop_permit))
        else $error("pop without word or permit");
    AST_DESKEW_WIDTH: assert property (s_pop_end |-> $past(pop_len) >= DESKEW_CYCLES)
        else $error("deskew interval too short");
    AST_LOAD_AFTER_POP: assert property (s_pop_end |-> s_load_run)
        else $error("load pulse did not follow pop");
    AST_STOP_NEVER_VALID: assert property ($rose(holding_valid_flag_o) |-> !stop_latched)
        else $error("stop marker marked valid");
    AST_VALID_BLOCKS: assert property (holding_valid_flag_o && !fifo_pop_o |=> !fifo_pop_o)
        else $error("pop started while holding full");
    AST_MISMATCH_FREEZE: assert property (holding_valid_flag_o && compare_mismatch_i
        && !write_mode_i && !rd_strobe_q && !clear_q |=> holding_valid_flag_o)
        else $error("holding register not frozen on mismatch");
    AST_DRIVE_GATED: assert property (drive_clk_o
        |-> !$past(inhibit) && !$past(device_count_overflow_i))
        else $error("drive clock passed while inhibited");
    AST_INHIBIT: assert property (err_flag || underrun |-> device_clock_inhibit_o ##1 !drive_clk_o)
        else $error("inhibit missing or drive clock passed on error");
    AST_CLEAR_WIDTH: assert property ($fell(fifo_clear_pulse_o) |-> $past(clr_len) >= CLEAR_CYCLES)
        else $error("fifo clear pulse too short");

endmodule : sodcc_output

// ---- verification/sodcc_drive_model.sv ----
// behavioural drive model: makes the sync clock and takes returned write data
`timescale 1ns/1ns
module sodcc_drive_model
    import sodcc_pkg::*;
#(
    parameter int HALF_NS = 80
) (
    input wire logic frame_i,
    input wire logic write_clk_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic sync_clk_o,
    output logic [DATA_W-1:0] taken_o
);
    // clock stands low between frames, as a real drive leaves it
    initial begin
        sync_clk_o = 1'h0;
        forever begin
            wait (frame_i);
            #HALF_NS sync_clk_o = 1'h1;
            #HALF_NS sync_clk_o = 1'h0;
        end
    end
    // leading edge of the returned clock captures the word on the lines
    initial begin
        taken_o = 18'h00000;
        forever begin
            @(posedge write_clk_i);
            taken_o <= data_i;
        end
    end
endmodule : sodcc_drive_model

// ---- verification/sodcc_output_tb.sv ----
// self-checking bench for the fifo output stage and drive clock control
`timescale 1ns/1ns
module sodcc_output_tb
    import sodcc_pkg::*;
();
    logic clock_i = 1'h0;
    logic rst_i = 1'h1;
    logic clk_en_i = 1'h1;
    logic frame = 1'h0;
    logic [FIFO_CHIPS-1:0] fifo_out_ready_i = 5'h00;
    logic [DATA_W-1:0] fifo_data_i = 18'h00000;
    logic stop_marker_at_top_i = 1'h0, write_mode_i = 1'h0, read_or_verify_mode_i = 1'h0;
    logic data_strobe_i = 1'h0, compare_mismatch_i = 1'h0, buffer_register_read_select_i = 1'h0;
    logic buffer_read_cycle_strobe_i = 1'h0, final_word_flag_i = 1'h0;
    logic device_count_overflow_i = 1'h0, control_status_two_write_i = 1'h0;
    logic bus_init_i = 1'h0, power_fail_indication_i = 1'h0, command_start_clear_i = 1'h0;
    logic sync_clk_i;
    logic [CSR_W-1:0] control_status_one_i = 16'h0000, control_status_two_data_i = 16'h0000;
    logic top_word_available_o, fifo_pop_o, holding_load_pulse_o, holding_valid_flag_o;
    logic output_underrun_flag_o, data_late_error_o, transfer_error_flag_o;
    logic device_clock_inhibit_o, drive_clk_o, write_clk_o, fifo_clear_pulse_o;
    logic [DATA_W-1:0] output_holding_register_o, taken;
    int n_errors = 0;
    int checks_done = 0;

    sodcc_output uut (.clock_i, .rst_i, .clk_en_i, .fifo_out_ready_i, .fifo_data_i,
        .stop_marker_at_top_i, .sync_clk_i, .write_mode_i, .read_or_verify_mode_i,
        .data_strobe_i, .compare_mismatch_i, .buffer_register_read_select_i,
        .buffer_read_cycle_strobe_i, .final_word_flag_i, .device_count_overflow_i,
        .control_status_one_i, .control_status_two_write_i, .control_status_two_data_i,
        .bus_init_i, .power_fail_indication_i, .command_start_clear_i, .top_word_available_o,
        .fifo_pop_o, .holding_load_pulse_o, .output_holding_register_o, .holding_valid_flag_o,
        .output_underrun_flag_o, .data_late_error_o, .transfer_error_flag_o,
        .device_clock_inhibit_o, .drive_clk_o, .write_clk_o, .fifo_clear_pulse_o);
    sodcc_drive_model drive (.frame_i(frame), .write_clk_i(write_clk_o),
        .data_i(output_holding_register_o), .sync_clk_o(sync_clk_i), .taken_o(taken));

    initial forever #2 clock_i = ~clock_i;

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [DATA_W-1:0] ext(input logic x);
        return {17'h00000, x};
    endfunction : ext

    // outputs watched by the bounded waits, picked by number
    function automatic logic mon(input int k);
        case (k)
            0: return fifo_pop_o;
            1: return holding_valid_flag_o;
            2: return fifo_clear_pulse_o;
            3: return drive_clk_o;
            4: return output_underrun_flag_o;
            5: return transfer_error_flag_o;
            default: return holding_load_pulse_o;
        endcase
    endfunction : mon

    // sampling on the falling edge keeps every look clear of the update edge
    task automatic wait_mon(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (mon(k) !== v) begin
            @(negedge clock_i);
            n++;
            if (n > lim) begin
                n_errors++;
                $display("MISMATCH wait on signal %0d expected %h seen %h", k, v, mon(k));
                summarize();
            end
        end
    endtask : wait_mon

    task automatic stays(input string what, input int k, input logic v, input int n);
        logic bad;
        bad = 1'h0;
        repeat (n) begin
            @(negedge clock_i);
            bad |= (mon(k) !== v);
        end
        chk(what, 18'h00000, ext(bad));
    endtask : stays

    // chips drop ready once they see the pop, as real fifo parts do
    task automatic load_word(input logic [DATA_W-1:0] d, input logic stop);
        int n;
        fifo_data_i = d;
        stop_marker_at_top_i = stop;
        fifo_out_ready_i = 5'h1F;
        wait_mon(0, 1'h1, 20, n);
        fifo_out_ready_i = 5'h00;
        stop_marker_at_top_i = 1'h0;
        wait_mon(6, 1'h1, 40, n);
        wait_mon(6, 1'h0, 40, n);
        chk("load_width", 18'(DESKEW_CYCLES), 18'(n));
        @(negedge clock_i);
    endtask : load_word

    task automatic bus_read;
        buffer_register_read_select_i = 1'h1;
        buffer_read_cycle_strobe_i = 1'h1;
        repeat (4) @(negedge clock_i);
        buffer_read_cycle_strobe_i = 1'h0;
        repeat (2) @(negedge clock_i);
        buffer_register_read_select_i = 1'h0;
        @(negedge clock_i);
    endtask : bus_read

    task automatic strobe_pulse;
        data_strobe_i = 1'h1;
        repeat (4) @(negedge clock_i);
        data_strobe_i = 1'h0;
        repeat (3) @(negedge clock_i);
    endtask : strobe_pulse

    // ***********************************************
    // scenarios
    // ***********************************************
    task automatic t_fifo_pop;
        fifo_out_ready_i = 5'h0F;
        stays("pop_partial", 0, 1'h0, 30);
        chk("avail_partial", 18'h00000, ext(top_word_available_o));
        fifo_out_ready_i = 5'h17;
        stays("pop_partial2", 0, 1'h0, 30);
        load_word(18'h2A5C3, 1'h0);
        chk("valid", 18'h00001, ext(holding_valid_flag_o));
        chk("holding", 18'h2A5C3, output_holding_register_o);
        fifo_data_i = 18'h1B7E4;
        fifo_out_ready_i = 5'h1F;
        stays("pop_full", 0, 1'h0, 40);
        chk("avail_full", 18'h00001, ext(top_word_available_o));
    endtask : t_fifo_pop

    task automatic t_buffer_read;
        int n;
        bus_read;
        chk("valid_read", 18'h00000, ext(holding_valid_flag_o));
        wait_mon(0, 1'h1, 20, n);
        fifo_out_ready_i = 5'h00;
        wait_mon(1, 1'h1, 80, n);
        chk("holding2", 18'h1B7E4, output_holding_register_o);
        bus_read;
        bus_read;
        chk("underrun", 18'h00003, {16'h0000, data_late_error_o, device_clock_inhibit_o});
    endtask : t_buffer_read

    task automatic t_clear;
        int n;
        for (int k = 0; k < 4; k++) begin
            bus_init_i = (k == 0);
            power_fail_indication_i = (k == 1);
            command_start_clear_i = (k == 2);
            control_status_two_write_i = (k == 3);
            control_status_two_data_i = 16'h0020;
            @(negedge clock_i);
            {bus_init_i, power_fail_indication_i, command_start_clear_i} = 3'h0;
            control_status_two_write_i = 1'h0;
            wait_mon(2, 1'h1, 4, n);
            wait_mon(2, 1'h0, 200, n);
            chk("clear_width", 18'h00001, ext(n >= 100));
            chk("flags_clear", 18'h00000, {16'h0000, output_underrun_flag_o, transfer_error_flag_o});
        end
        control_status_two_write_i = 1'h1;
        control_status_two_data_i = 16'hFFDF;
        @(negedge clock_i);
        control_status_two_write_i = 1'h0;
        stays("clear_other_bits", 2, 1'h0, 20);
        clk_en_i = 1'h0;
        control_status_two_write_i = 1'h1;
        control_status_two_data_i = 16'h0020;
        @(negedge clock_i);
        control_status_two_write_i = 1'h0;
        stays("clear_frozen", 2, 1'h0, 10);
        clk_en_i = 1'h1;
        stays("clear_after_freeze", 2, 1'h0, 10);
    endtask : t_clear

    task automatic t_stop_verify;
        load_word(18'h3FFFF, 1'h1);
        chk("valid_stop", 18'h00000, ext(holding_valid_flag_o));
        read_or_verify_mode_i = 1'h1;
        load_word(18'h0F0F0, 1'h0);
        compare_mismatch_i = 1'h1;
        strobe_pulse;
        chk("valid_mismatch", 18'h00001, ext(holding_valid_flag_o));
        compare_mismatch_i = 1'h0;
        strobe_pulse;
        chk("valid_strobe", 18'h00000, ext(holding_valid_flag_o));
        read_or_verify_mode_i = 1'h0;
    endtask : t_stop_verify

    task automatic t_write;
        int n;
        write_mode_i = 1'h1;
        final_word_flag_i = 1'h1;
        load_word(18'h15A5A, 1'h0);
        frame = 1'h1;
        wait_mon(3, 1'h1, 60, n);
        chk("write_clk", 18'h00001, ext(write_clk_o));
        wait_mon(3, 1'h0, 60, n);
        wait_mon(1, 1'h0, 8, n);
        chk("drive_took", 18'h15A5A, taken);
        chk("no_underrun_final", 18'h00000, ext(output_underrun_flag_o));
        final_word_flag_i = 1'h0;
        wait_mon(4, 1'h1, 80, n);
        stays("drive_inhibit", 3, 1'h0, 100);
        frame = 1'h0;
        write_mode_i = 1'h0;
    endtask : t_write

    task automatic t_error;
        int n;
        device_count_overflow_i = 1'h1;
        frame = 1'h1;
        stays("drive_overflow", 3, 1'h0, 100);
        device_count_overflow_i = 1'h0;
        wait_mon(3, 1'h1, 60, n);
        chk("write_clk_read", 18'h00000, ext(write_clk_o));
        control_status_one_i = 16'h4000;
        wait_mon(5, 1'h1, 60, n);
        chk("inhibit_err", 18'h00001, ext(device_clock_inhibit_o));
        control_status_one_i = 16'h0000;
        wait_mon(3, 1'h0, 60, n);
        stays("drive_error", 3, 1'h0, 100);
        stays("error_held", 5, 1'h1, 60);
        frame = 1'h0;
    endtask : t_error

    initial begin
        int n;
        repeat (6) @(negedge clock_i);
        rst_i = 1'h0;
        wait_mon(2, 1'h1, 5, n);
        wait_mon(2, 1'h0, 200, n);
        chk("reset_clear_width", 18'h00001, ext(n >= 100));
        t_fifo_pop;
        t_buffer_read;
        t_clear;
        t_stop_verify;
        t_write;
        t_clear;
        t_error;
        t_clear;
        summarize();
    end
endmodule : sodcc_output_tb
